// >>> src/ptads_fifo.sv
`timescale 1ns/1ps
module ptads_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    ptads_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    assign f.in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign f.out_valid = (cnt_ff != '0);
    assign f.out_data = mem_ff[rd_ff];
    assign push = f.in_valid && f.in_ready;
    assign pop = f.out_valid && f.out_ready;

    always_comb begin
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_wr = (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
        end
        if (pop) begin
            nxt_rd = (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // storage has no reset; empty flag hides stale words
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= f.in_data;
        end
    end
endmodule : ptads_fifo

// >>> src/ptads_fifo_if.sv
`timescale 1ns/1ps
interface ptads_fifo_if #(parameter int WIDTH = 9);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport fifo (input in_valid, output in_ready, input in_data,
                  output out_valid, input out_ready, output out_data);
    modport user (output in_valid, input in_ready, output in_data,
                  input out_valid, output out_ready, input out_data);
endinterface : ptads_fifo_if

// >>> src/ptads_pkg.sv
package ptads_pkg;
    localparam int CLK_MHZ = 20;
    localparam real T_SAMPLE_US = 1.5;
    localparam real T_FIRST_BIT_US = 6.0;
    localparam real T_BIT_US = 2.0;
    localparam real T_HOLD_US = 23.0;
    localparam real T_DONE_US = 24.5;
    localparam real T_DAC_US = 3.0;
    localparam real T_DAC_MAX_US = 6.0;
    localparam int SAMPLE_CYC = int'(T_SAMPLE_US * CLK_MHZ);
    localparam int FIRST_BIT_CYC = int'(T_FIRST_BIT_US * CLK_MHZ);
    localparam int BIT_CYC = int'(T_BIT_US * CLK_MHZ);
    localparam int HOLD_CYC = int'(T_HOLD_US * CLK_MHZ);
    localparam int DONE_CYC = int'(T_DONE_US * CLK_MHZ);
    localparam int DAC_CYC = int'(T_DAC_US * CLK_MHZ);
    localparam int DAC_MAX_CYC = int'(T_DAC_MAX_US * CLK_MHZ);
    localparam int NBITS = 9;
    localparam int SKIP_POS = 2;
    localparam int FIFO_DEPTH = 8;
    localparam logic [8:0] WORD_RST = 9'h000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADC = 3'b001,
        ST_DAC_WAIT = 3'b010,
        ST_DAC_SETTLE = 3'b011
    } ptads_state_e;
endpackage : ptads_pkg

// >>> src/ptads_seq.sv
`timescale 1ns/1ps
module ptads_seq #(
    parameter int NB = ptads_pkg::NBITS,
    parameter int DEPTH = ptads_pkg::FIFO_DEPTH
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic MODE_DAC,
    input wire logic START_CMD,
    input wire logic COMPARE_HIGH,
    input wire logic DAC_CLEAR,
    input wire logic [NB-1:0] DAC_WORD,
    input wire logic REC_READY,
    output logic SAMPLE_EN,
    output logic [NB-1:0] TRIAL_WORD,
    output logic [NB-1:0] RESULT_WORD,
    output logic CONV_DONE,
    output logic [NB-1:0] REC_WORD,
    output logic REC_VALID,
    output logic [NB-1:0] DAC_OUT,
    output logic ANALOG_VALID,
    output logic BUSY,
    output logic OVERRUN
);
    localparam int CW = 10;
    ptads_pkg::ptads_state_e st_ff, nxt_st;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [NB-1:0] trial_ff, nxt_trial;
    logic [NB-1:0] res_ff, nxt_res;
    logic [NB-1:0] dac_ff, nxt_dac;
    logic [3:0] bit_ff, nxt_bit;
    logic samp_ff, nxt_samp;
    logic done_ff, nxt_done;
    logic aval_ff, nxt_aval;
    logic ovr_ff, nxt_ovr;
    logic push;

    ptads_fifo_if #(.WIDTH(NB)) fq ();

    ptads_fifo #(.WIDTH(NB), .DEPTH(DEPTH)) u_fifo (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .f(fq)
    );

    // word queued to recorder on complete pulse
    assign push = done_ff;
    assign fq.in_valid = push;
    assign fq.in_data = res_ff;
    assign fq.out_ready = REC_READY;

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_trial = trial_ff;
        nxt_res = res_ff;
        nxt_dac = dac_ff;
        nxt_bit = bit_ff;
        nxt_samp = 1'b0;
        nxt_done = 1'b0;
        nxt_aval = aval_ff;
        nxt_ovr = ovr_ff;
        if (push && !fq.in_ready) begin
            nxt_ovr = 1'b1;
        end
        case (st_ff)
            ptads_pkg::ST_IDLE: begin
                // mode only sampled here, so mid-run changes wait
                if (!MODE_DAC && START_CMD) begin
                    nxt_st = ptads_pkg::ST_ADC;
                    nxt_cnt = '0;
                    nxt_res = ptads_pkg::WORD_RST;
                    nxt_trial = '0;
                    nxt_bit = '0;
                    nxt_samp = 1'b1;
                end else if (MODE_DAC && DAC_CLEAR) begin
                    nxt_st = ptads_pkg::ST_DAC_WAIT;
                    nxt_dac = '0;
                    nxt_aval = 1'b0;
                end
            end
            ptads_pkg::ST_ADC: begin
                nxt_cnt = cnt_ff + 1'b1;
                nxt_samp = (cnt_ff < CW'(ptads_pkg::SAMPLE_CYC - 1));
                // first trial sets the MSB here; all nine bits are then decided and kept
                if (cnt_ff == CW'(ptads_pkg::FIRST_BIT_CYC - 1)) begin
                    nxt_trial = NB'(1) << (NB - 1);
                end else if (cnt_ff >= CW'(ptads_pkg::FIRST_BIT_CYC) &&
                             bit_ff < 4'(NB) &&
                             (cnt_ff - CW'(ptads_pkg::FIRST_BIT_CYC)) %
                             CW'(ptads_pkg::BIT_CYC) ==
                             CW'(ptads_pkg::BIT_CYC - 1)) begin
                    nxt_trial = trial_ff;
                    if (!COMPARE_HIGH) begin
                        nxt_trial[NB-1-bit_ff] = 1'b0;
                    end
                    if (bit_ff < 4'(NB - 1)) begin
                        nxt_trial[NB-2-bit_ff] = 1'b1;
                    end
                    nxt_bit = bit_ff + 1'b1;
                    // ninth bit lands after the 23 us hold, so latch on it
                    if (bit_ff == 4'(NB - 1)) begin
                        nxt_res = nxt_trial;
                    end
                end
                if (cnt_ff == CW'(ptads_pkg::DONE_CYC - 1)) begin
                    nxt_done = 1'b1;
                    nxt_st = ptads_pkg::ST_IDLE;
                end
            end
            ptads_pkg::ST_DAC_WAIT: begin
                if (DAC_CLEAR) begin
                    nxt_dac = '0;
                end else begin
                    nxt_dac = DAC_WORD;
                    nxt_cnt = '0;
                    nxt_st = ptads_pkg::ST_DAC_SETTLE;
                end
            end
            ptads_pkg::ST_DAC_SETTLE: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == CW'(ptads_pkg::DAC_CYC - 1)) begin
                    nxt_aval = 1'b1;
                    nxt_st = ptads_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_st = ptads_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            st_ff <= ptads_pkg::ST_IDLE;
            cnt_ff <= '0;
            trial_ff <= '0;
            res_ff <= ptads_pkg::WORD_RST;
            dac_ff <= '0;
            bit_ff <= '0;
            samp_ff <= 1'b0;
            done_ff <= 1'b0;
            aval_ff <= 1'b0;
            ovr_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            trial_ff <= nxt_trial;
            res_ff <= nxt_res;
            dac_ff <= nxt_dac;
            bit_ff <= nxt_bit;
            samp_ff <= nxt_samp;
            done_ff <= nxt_done;
            aval_ff <= nxt_aval;
            ovr_ff <= nxt_ovr;
        end
    end

    assign SAMPLE_EN = samp_ff;
    assign TRIAL_WORD = trial_ff;
    assign RESULT_WORD = res_ff;
    assign CONV_DONE = done_ff;
    assign REC_WORD = fq.out_data;
    assign REC_VALID = fq.out_valid;
    assign DAC_OUT = dac_ff;
    assign ANALOG_VALID = aval_ff;
    assign BUSY = (st_ff != ptads_pkg::ST_IDLE);
    assign OVERRUN = ovr_ff;
endmodule : ptads_seq

// >>> verif/ptads_rec_model.sv
`timescale 1ns/1ps
module ptads_rec_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic [8:0] level,
    input wire logic [8:0] trial,
    input wire logic [8:0] rec_word,
    input wire logic rec_valid,
    output logic compare_high,
    output logic rec_ready
);
    logic [8:0] got [$];
    // ideal comparator, no offset or noise
    assign compare_high = level >= trial;
    // stall lets the queue fill up to overflow
    assign rec_ready = !stall;
    always @(posedge clk) begin
        if (rst_n && rec_valid && rec_ready) begin
            got.push_back(rec_word);
        end
    end
endmodule : ptads_rec_model

// >>> verif/ptads_seq_assertions.sv
`timescale 1ns/1ps
module ptads_seq_chk (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic MODE_DAC,
    input wire logic START_CMD,
    input wire logic DAC_CLEAR,
    input wire logic [8:0] DAC_WORD,
    input wire logic SAMPLE_EN,
    input wire logic [8:0] TRIAL_WORD,
    input wire logic [8:0] RESULT_WORD,
    input wire logic CONV_DONE,
    input wire logic REC_VALID,
    input wire logic [8:0] DAC_OUT,
    input wire logic ANALOG_VALID,
    input wire logic BUSY,
    input wire logic OVERRUN
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);
    wire logic go = !BUSY && !MODE_DAC && START_CMD;
    wire logic dgo = !BUSY && MODE_DAC && DAC_CLEAR;
    sequence dld;
        BUSY && MODE_DAC && $fell(DAC_CLEAR);
    endsequence
    chk_start_clear: assert property (go |=> SAMPLE_EN && BUSY
        && RESULT_WORD == 9'h000) else $error("start not taken");
    chk_sample_win: assert property (
        go |-> ##30 SAMPLE_EN ##1 !SAMPLE_EN) else $error("sample window");
    chk_first_bit: assert property (
        go |-> ##120 TRIAL_WORD == 9'h000 ##1 TRIAL_WORD == 9'h100)
        else $error("first trial");
    chk_done_time: assert property (
        go |-> ##[490:490] !CONV_DONE ##1 CONV_DONE)
        else $error("done timing");
    chk_done_pulse: assert property (
        CONV_DONE |-> !BUSY ##1 !CONV_DONE) else $error("done pulse");
    chk_overrun_stick: assert property (
        OVERRUN |=> OVERRUN) else $error("overrun dropped");
    chk_result_hold: assert property (
        $changed(RESULT_WORD) |-> BUSY) else $error("result moved");
    chk_word_push: assert property (
        CONV_DONE |=> REC_VALID) else $error("word not queued");
    chk_start_gate: assert property (
        $rose(SAMPLE_EN) |-> $past(go)) else $error("overlap start");
    chk_dac_clear: assert property (dgo |=> BUSY && !ANALOG_VALID
        && DAC_OUT == 9'h000 && !SAMPLE_EN) else $error("dac clear");
    chk_dac_load: assert property (
        dld |=> DAC_OUT == $past(DAC_WORD)) else $error("dac load");
    chk_dac_time: assert property (dld |-> ##60 !ANALOG_VALID
        ##1 ANALOG_VALID && !BUSY) else $error("dac settle");
    cover property (go);
    cover property (dld ##61 ANALOG_VALID);
    cover property ($rose(OVERRUN));
endmodule : ptads_seq_chk

bind ptads_seq ptads_seq_chk i_ptads_seq_chk (.CORE_CLK, .RST_N, .MODE_DAC,
    .START_CMD, .DAC_CLEAR, .DAC_WORD, .SAMPLE_EN, .TRIAL_WORD,
    .RESULT_WORD, .CONV_DONE, .REC_VALID, .DAC_OUT, .ANALOG_VALID, .BUSY,
    .OVERRUN);

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mode = 1'b0;
    logic start = 1'b0;
    logic clr = 1'b0;
    logic stall = 1'b1;
    logic [8:0] word = 9'h000;
    logic [8:0] lvl = 9'h000;
    logic [8:0] trial, result, rec_word, dac_out;
    logic cmp, rdy, samp, done, rvalid, avalid, busy, ovr;
    int n_errors = 0;
    int comparisons = 0;
    always #25 clk = ~clk;
    ptads_seq i_ptads_seq (.CORE_CLK(clk), .RST_N(rst_n), .MODE_DAC(mode),
        .START_CMD(start), .COMPARE_HIGH(cmp), .DAC_CLEAR(clr),
        .DAC_WORD(word), .REC_READY(rdy), .SAMPLE_EN(samp),
        .TRIAL_WORD(trial), .RESULT_WORD(result), .CONV_DONE(done),
        .REC_WORD(rec_word), .REC_VALID(rvalid), .DAC_OUT(dac_out),
        .ANALOG_VALID(avalid), .BUSY(busy), .OVERRUN(ovr));
    ptads_rec_model i_ptads_rec_model (.clk(clk), .rst_n(rst_n),
        .stall(stall), .level(lvl), .trial(trial), .rec_word(rec_word),
        .rec_valid(rvalid), .compare_high(cmp), .rec_ready(rdy));
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    task automatic check(logic [8:0] seen, logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    function automatic logic hit(int w);
        return (w == 0 ? done : w == 1 ? avalid : !rvalid) === 1'b1;
    endfunction : hit
    task automatic wait_on(int w);
        int k;
        for (k = 0; k < 700 && !hit(w); k++) tick;
        if (!hit(w)) begin
            n_errors++;
            tally_and_finish;
        end
    endtask : wait_on
    function automatic logic [8:0] lv(int i);
        return (i == 1) ? 9'h1ff : i[8:0] * 9'h039;
    endfunction : lv
    task automatic t_adc(logic [8:0] v, logic stray);
        lvl = v;
        start = 1'b1;
        tick;
        start = 1'b0;
        check(result, 9'h000);
        repeat (40) tick;
        start = stray;
        tick;
        start = 1'b0;
        wait_on(0);
        tick;
        check(result, v);
    endtask : t_adc
    task automatic t_fill;
        int i;
        for (i = 0; i < 9; i++) t_adc(lv(i), i[0]);
        check({8'h00, ovr}, 9'h001);
    endtask : t_fill
    task automatic t_dac(logic [8:0] w);
        mode = 1'b1;
        clr = 1'b1;
        tick;
        clr = 1'b0;
        word = w;
        start = 1'b1;
        tick;
        start = 1'b0;
        word = ~w;
        tick;
        check({8'h00, samp}, 9'h000);
        check({8'h00, avalid}, 9'h000);
        wait_on(1);
        check(dac_out, w);
        tick;
    endtask : t_dac
    task automatic t_drain;
        int i;
        stall = 1'b0;
        wait_on(2);
        check(9'(i_ptads_rec_model.got.size()), 9'h008);
        for (i = 0; i < 8; i++) check(i_ptads_rec_model.got[i], lv(i));
    endtask : t_drain
    initial begin
        repeat (2) tick;
        rst_n = 1'b1;
        t_fill;
        t_dac(9'h1ff);
        t_dac(9'h0c3);
        mode = 1'b0;
        t_drain;
        t_adc(9'h0aa, 1'b1);
        tally_and_finish;
    end
endmodule : tb_top
